// file: logic/dtc_pkg.sv
// dtc_pkg: constants, types and register map of the dual timer/counter
// assumes: APB with 32-bit data, one register per aligned word
`default_nettype none
package dtc_pkg;

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_TLA = 8'h8a;
    localparam logic [7:0] IDX_TLB = 8'h8b;
    localparam logic [7:0] IDX_THA = 8'h8c;
    localparam logic [7:0] IDX_THB = 8'h8d;
    localparam logic [7:0] IDX_STAT = 8'h8e;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_FLAG_B = 7;
    localparam int CTRL_RUN_B = 6;
    localparam int CTRL_FLAG_A = 5;
    localparam int CTRL_RUN_A = 4;
    localparam int MODE_GATE_B = 7;
    localparam int MODE_SRC_B = 6;
    localparam int MODE_FIELD_B = 4;
    localparam int MODE_GATE_A = 3;
    localparam int MODE_SRC_A = 2;
    localparam int MODE_FIELD_A = 0;
    localparam int PRESCALE_BITS = 5;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [3:0] MC_OSC_PERIODS = 4'hc;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_PRESCALED = 2'b00,
        MODE_CASCADED = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } dtc_mode_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } dtc_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dtc_apb_rsp_s;

    typedef struct packed {
        logic timer_a_count_pin;
        logic timer_b_count_pin;
        logic timer_a_gate_pin;
        logic timer_b_gate_pin;
    } dtc_pins_s;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] tla;
        logic [7:0] tha;
        logic [7:0] tlb;
        logic [7:0] thb;
        logic [31:0] rdata;
    } dtc_regs_s;

endpackage
`default_nettype wire

// file: logic/dtc_mcycle.sv
// dtc_mcycle: machine-cycle tick, one pulse every twelve clocks
// assumes: pclk is the oscillator clock
`default_nettype none
`timescale 1ns/100ps
module dtc_mcycle (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // tick out
    output logic tick
);
    typedef struct packed {
        logic [3:0] cnt;
    } dtc_mc_s;

    dtc_mc_s r;
    dtc_mc_s n;

    always_comb begin
        n = r;
        if (r.cnt == dtc_pkg::MC_OSC_PERIODS - 4'h1) begin
            n.cnt = 4'h0;
        end else begin
            n.cnt = r.cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = (r.cnt == dtc_pkg::MC_OSC_PERIODS - 4'h1); // RULE_17
endmodule // dtc_mcycle
`default_nettype wire

// file: logic/dtc_fall_det.sv
// dtc_fall_det: count-pin sampler, one sample per machine cycle
// assumes: pin synchronous to pclk, tick from dtc_mcycle
`default_nettype none
`timescale 1ns/100ps
module dtc_fall_det (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sampling
    input wire logic tick,
    input wire logic pin,
    // event out
    output logic fall
);
    typedef struct packed {
        logic cur;
        logic prev;
    } dtc_fd_s;

    dtc_fd_s r;
    dtc_fd_s n;

    always_comb begin
        n = r;
        if (tick) begin
            n.prev = r.cur;
            n.cur = pin;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // high then low seen, counted at the following tick
    assign fall = tick & r.prev & ~r.cur; // RULE_18
endmodule // dtc_fall_det
`default_nettype wire

// file: logic/dtc_timers.sv
// dtc_timers: two timer/counters with four modes, APB register slave
// assumes: APB master on pclk, gate and count pins synchronous to pclk
//
// Contract
// RULE_01: timer counts only while run bit set
// RULE_02: overflow sets flag, vector acknowledge clears it
// RULE_03: gate bit adds gate pin high condition
// RULE_04: source bit picks count pin or clock
// RULE_05: two-bit mode field selects four modes
// RULE_06: mode 0 is 13 bits, high three ignored
// RULE_07: mode 0 wrap sets overflow flag
// RULE_08: gate bits at mode bit 7 and 3
// RULE_09: setting run bit keeps counter value
// RULE_10: mode 1 as mode 0 with 16 bits
// RULE_11: mode 2 reloads low from high byte
// RULE_12: timer b in mode 3 holds count
// RULE_13: split low byte uses timer a controls
// RULE_14: split high byte counts cycles, timer b
// RULE_15: software toggles timer b via mode 3
// RULE_16: control register layout, resets to zero
// RULE_17: timer operation ticks every machine cycle
// RULE_18: counter operation counts sampled falling edges
// RULE_19: counter bytes reset to zero
// RULE_20: software byte write beats increment
// RULE_21: software may set or clear flags
`default_nettype none
`timescale 1ns/100ps
module dtc_timers (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire dtc_pkg::dtc_apb_req_s apb_req,
    output dtc_pkg::dtc_apb_rsp_s apb_rsp,
    // count and gate pins
    input wire dtc_pkg::dtc_pins_s pins,
    // interrupt vector acknowledge
    input wire logic vector_ack_a,
    input wire logic vector_ack_b,
    // overflow flags
    output logic timer_a_overflow_flag,
    output logic timer_b_overflow_flag
);

    // ------------------------------------------------------------
    // count step for modes 0 to 2, result {ovf, hi, lo}
    // ------------------------------------------------------------
    function automatic logic [16:0] dtc_step(
        input logic [1:0] m,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [16:0] res;
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        res = {1'b0, hi, lo};
        c13 = {1'b0, hi, lo[dtc_pkg::PRESCALE_BITS-1:0]} + 14'h0001;
        c16 = {1'b0, hi, lo} + 17'h00001;
        c8 = {1'b0, lo} + 9'h001;
        unique case (m)
            dtc_pkg::MODE_PRESCALED: begin
                // upper three low bits left as they are
                res = {c13[13], c13[12:5], lo[7:5], c13[4:0]}; // RULE_06 RULE_07
            end
            dtc_pkg::MODE_CASCADED: begin
                res = c16; // RULE_10
            end
            dtc_pkg::MODE_RELOAD: begin
                if (c8[8]) begin
                    res = {1'b1, hi, hi}; // RULE_11
                end else begin
                    res = {1'b0, hi, c8[7:0]};
                end
            end
            dtc_pkg::MODE_SPLIT: begin
                res = {1'b0, hi, lo};
            end
        endcase
        return res;
    endfunction

    // ------------------------------------------------------------
    // machine cycle and count pin sampling
    // ------------------------------------------------------------
    logic tick;
    logic fall_a;
    logic fall_b;

    dtc_mcycle u_mcycle (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    dtc_fall_det u_fall_a (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .pin(pins.timer_a_count_pin),
        .fall(fall_a)
    );

    dtc_fall_det u_fall_b (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .pin(pins.timer_b_count_pin),
        .fall(fall_b)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dtc_pkg::dtc_regs_s r;
    dtc_pkg::dtc_regs_s n;

    logic [7:0] idx;
    logic setup;
    logic access;
    logic hit;
    logic wr;
    logic [7:0] wbyte;
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic split;
    logic gate_ok_a;
    logic gate_ok_b;
    logic en_a;
    logic en_b;
    logic inc_a;
    logic inc_b;
    logic inc_th;
    logic [16:0] step_a;
    logic [16:0] step_b;
    logic [8:0] split_lo;
    logic [8:0] split_hi;
    logic ovf_a;
    logic ovf_b;
    logic [7:0] rmux;

    // ------------------------------------------------------------
    // enables and count sources
    // ------------------------------------------------------------
    always_comb begin
        mode_a = r.mode[dtc_pkg::MODE_FIELD_A +: 2]; // RULE_05
        mode_b = r.mode[dtc_pkg::MODE_FIELD_B +: 2]; // RULE_05
        split = (mode_a == dtc_pkg::MODE_SPLIT);
        // gate bit set: pin must be high too
        gate_ok_a = ~r.mode[dtc_pkg::MODE_GATE_A] | pins.timer_a_gate_pin; // RULE_03 RULE_08
        gate_ok_b = ~r.mode[dtc_pkg::MODE_GATE_B] | pins.timer_b_gate_pin; // RULE_03 RULE_08
        en_a = r.ctrl[dtc_pkg::CTRL_RUN_A] & gate_ok_a; // RULE_01 RULE_13
        // run bit b is lent to the split high byte
        if (split) begin
            en_b = gate_ok_b; // RULE_15
        end else begin
            en_b = r.ctrl[dtc_pkg::CTRL_RUN_B] & gate_ok_b; // RULE_01
        end
        if (mode_b == dtc_pkg::MODE_SPLIT) begin
            en_b = 1'b0; // RULE_12
        end
        if (r.mode[dtc_pkg::MODE_SRC_A]) begin
            inc_a = en_a & fall_a; // RULE_04 RULE_18
        end else begin
            inc_a = en_a & tick; // RULE_04 RULE_17
        end
        if (r.mode[dtc_pkg::MODE_SRC_B]) begin
            inc_b = en_b & fall_b; // RULE_04 RULE_18
        end else begin
            inc_b = en_b & tick; // RULE_04 RULE_17
        end
        // split high byte: machine cycles only
        inc_th = split & tick & r.ctrl[dtc_pkg::CTRL_RUN_B]; // RULE_14
    end

    // ------------------------------------------------------------
    // counter arithmetic
    // ------------------------------------------------------------
    always_comb begin
        step_a = dtc_step(mode_a, r.tla, r.tha);
        step_b = dtc_step(mode_b, r.tlb, r.thb);
        split_lo = {1'b0, r.tla} + 9'h001; // RULE_13
        split_hi = {1'b0, r.tha} + 9'h001; // RULE_14
    end

    // ------------------------------------------------------------
    // apb decode and read mux
    // ------------------------------------------------------------
    always_comb begin
        idx = apb_req.paddr[9:2];
        setup = apb_req.psel & ~apb_req.penable;
        access = apb_req.psel & apb_req.penable;
        hit = (apb_req.paddr[11:10] == 2'b00)
            && (idx >= dtc_pkg::IDX_CTRL) && (idx <= dtc_pkg::IDX_STAT);
        wr = access & apb_req.pwrite & apb_req.pstrb[0] & hit;
        wbyte = apb_req.pwdata[7:0];
        rmux = 8'h00;
        if (apb_req.paddr[11:10] == 2'b00) begin
            unique case (idx)
                dtc_pkg::IDX_CTRL: rmux = r.ctrl;
                dtc_pkg::IDX_MODE: rmux = r.mode;
                dtc_pkg::IDX_TLA: rmux = r.tla;
                dtc_pkg::IDX_TLB: rmux = r.tlb;
                dtc_pkg::IDX_THA: rmux = r.tha;
                dtc_pkg::IDX_THB: rmux = r.thb;
                dtc_pkg::IDX_STAT: rmux = {5'h00, split, en_b, en_a};
                default: rmux = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        ovf_a = 1'b0;
        ovf_b = 1'b0;

        // timer a
        if (inc_a) begin
            if (split) begin
                n.tla = split_lo[7:0];
                ovf_a = split_lo[8]; // RULE_13
            end else begin
                {n.tha, n.tla} = step_a[15:0];
                ovf_a = step_a[16]; // RULE_07
            end
        end
        if (inc_th) begin
            n.tha = split_hi[7:0];
            ovf_b = split_hi[8]; // RULE_14
        end

        // timer b, its own flag is given to the split high byte
        if (inc_b) begin
            {n.thb, n.tlb} = step_b[15:0];
            if (!split) begin
                ovf_b = step_b[16]; // RULE_07
            end
        end

        // software byte writes win over counting
        if (wr) begin
            unique case (idx)
                dtc_pkg::IDX_MODE: n.mode = wbyte; // RULE_05
                dtc_pkg::IDX_TLA: n.tla = wbyte; // RULE_20
                dtc_pkg::IDX_TLB: n.tlb = wbyte; // RULE_20
                dtc_pkg::IDX_THA: n.tha = wbyte; // RULE_20
                dtc_pkg::IDX_THB: n.thb = wbyte; // RULE_20
                default: n.mode = r.mode;
            endcase
        end

        // control: ack clears, write loads, overflow set wins
        if (vector_ack_a) begin
            n.ctrl[dtc_pkg::CTRL_FLAG_A] = 1'b0; // RULE_02
        end
        if (vector_ack_b) begin
            n.ctrl[dtc_pkg::CTRL_FLAG_B] = 1'b0; // RULE_02
        end
        if (wr && idx == dtc_pkg::IDX_CTRL) begin
            // whole byte, run and flag bits; counters untouched
            n.ctrl = wbyte; // RULE_09 RULE_16 RULE_21
        end
        if (ovf_a) begin
            n.ctrl[dtc_pkg::CTRL_FLAG_A] = 1'b1; // RULE_02
        end
        if (ovf_b) begin
            n.ctrl[dtc_pkg::CTRL_FLAG_B] = 1'b1; // RULE_02
        end

        // read data captured in the setup cycle
        if (setup) begin
            n.rdata = {24'h000000, rmux};
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.ctrl <= dtc_pkg::CTRL_RST; // RULE_16
            r.mode <= dtc_pkg::MODE_RST;
            r.tla <= dtc_pkg::COUNT_RST; // RULE_19
            r.tha <= dtc_pkg::COUNT_RST; // RULE_19
            r.tlb <= dtc_pkg::COUNT_RST; // RULE_19
            r.thb <= dtc_pkg::COUNT_RST; // RULE_19
            r.rdata <= 32'h00000000;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        apb_rsp.prdata = r.rdata;
        apb_rsp.pready = 1'b1;
        apb_rsp.pslverr = access & ~hit;
    end

    assign timer_a_overflow_flag = r.ctrl[dtc_pkg::CTRL_FLAG_A];
    assign timer_b_overflow_flag = r.ctrl[dtc_pkg::CTRL_FLAG_B];

endmodule // dtc_timers
`default_nettype wire

// file: tb/dtc_timers_sva.sv
// dtc_timers_sva: port-level checks on dtc_timers
// assumes: machine-cycle tick on every twelfth pclk edge after reset release
`default_nettype none
`timescale 1ns/100ps
module dtc_timers_sva (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire dtc_pkg::dtc_apb_req_s apb_req,
    input wire dtc_pkg::dtc_apb_rsp_s apb_rsp,
    // pins, acknowledges, flags
    input wire dtc_pkg::dtc_pins_s pins,
    input wire logic vector_ack_a,
    input wire logic vector_ack_b,
    input wire logic timer_a_overflow_flag,
    input wire logic timer_b_overflow_flag
);
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------
    // tick phase
    // ----------------
    logic [3:0] ph_r;
    logic acc, rd, wr_ctl, bad, tick;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) ph_r <= 4'h0;
        else ph_r <= (ph_r == 4'hb) ? 4'h0 : ph_r + 4'h1;
    assign tick = ph_r == 4'hb;
    assign acc = apb_req.psel && apb_req.penable;
    assign rd = acc && !apb_req.pwrite;
    assign wr_ctl = acc && apb_req.pwrite && apb_req.pstrb[0] && apb_req.paddr == 12'h220;
    assign bad = apb_req.paddr < 12'h220 || apb_req.paddr > 12'h238;
    // ----------------
    // properties
    // ----------------
    a_map_error: assert property (acc && apb_req.paddr[1:0] == 2'b00 |->
        apb_rsp.pslverr == bad) else $error("slave error mismatch");
    a_err_idle: assert property (!acc |-> !apb_rsp.pslverr)
        else $error("slave error outside access");
    a_read_upper: assert property (rd |-> apb_rsp.prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_bad_zero: assert property (rd && bad |-> apb_rsp.prdata == 32'h0)
        else $error("unmapped read not zero");
    a_set_flag_a: assert property (wr_ctl && apb_req.pwdata[5] |=> timer_a_overflow_flag)
        else $error("flag a not set by write");
    a_set_flag_b: assert property (wr_ctl && apb_req.pwdata[7] |=> timer_b_overflow_flag)
        else $error("flag b not set by write");
    a_ack_clear_a: assert property (vector_ack_a && !wr_ctl && !tick |=>
        !timer_a_overflow_flag) else $error("flag a kept after ack");
    a_ack_clear_b: assert property (vector_ack_b && !wr_ctl && !tick |=>
        !timer_b_overflow_flag) else $error("flag b kept after ack");
    a_rise_cause: assert property ($rose(timer_a_overflow_flag) |->
        $past(tick) || $past(wr_ctl)) else $error("flag a rose off tick");
    a_fall_cause: assert property ($fell(timer_b_overflow_flag) |->
        $past(vector_ack_b || wr_ctl)) else $error("flag b fell uncaused");
    c_ack: cover property (vector_ack_a && timer_a_overflow_flag);
    c_ovf: cover property ($rose(timer_b_overflow_flag) && !$past(wr_ctl));
    c_err: cover property (acc && apb_rsp.pslverr);
endmodule // dtc_timers_sva
bind dtc_timers dtc_timers_sva u_sva (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pins(pins), .vector_ack_a(vector_ack_a), .vector_ack_b(vector_ack_b),
    .timer_a_overflow_flag(timer_a_overflow_flag),
    .timer_b_overflow_flag(timer_b_overflow_flag));
`default_nettype wire

// file: tb/dtc_pin_model.sv
// dtc_pin_model: count and gate pins as driven from outside
// assumes: go holds the pins idle, release starts three count pulses
`default_nettype none
`timescale 1ns/100ps
module dtc_pin_model (
    // clock
    input wire logic pclk,
    // bench control
    input wire logic go,
    input wire logic [1:0] gate,
    // pins
    output dtc_pkg::dtc_pins_s pins
);
    logic [7:0] t_r = 8'hff;
    logic lvl;
    always @(posedge pclk)
        t_r <= go ? 8'h0 : (t_r == 8'hff ? t_r : t_r + 8'h1);
    // each level held two machine cycles
    assign lvl = !(t_r >= 8'h18 && t_r < 8'h90 && ((t_r - 8'h18) % 8'h30) < 8'h18);
    assign pins = '{lvl, lvl, gate[0], gate[1]};
endmodule // dtc_pin_model
`default_nettype wire

// file: tb/tb_dual_timer_counter_modes.sv
// tb_dual_timer_counter_modes: self-checking bench for dtc_timers
// assumes: dtc_pin_model on the pins, checker bound from its own file
`default_nettype none
`timescale 1ns/100ps
module tb_dual_timer_counter_modes;
    // ----------------
    // setup
    // ----------------
    localparam logic [4:0] CFG [7] = '{5'h01, 5'h09, 5'h11, 5'h19, 5'h0d, 5'h0a, 5'h0b};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    dtc_pkg::dtc_apb_req_s req = '0;
    dtc_pkg::dtc_apb_rsp_s rsp;
    dtc_pkg::dtc_pins_s pins;
    logic ack_a = 1'b0;
    logic ack_b = 1'b0;
    logic go = 1'b1;
    logic [1:0] gate = 2'b11;
    logic fa, fb;
    logic [31:0] rnd = 32'h398360d9;
    logic [8:0] q[$];
    logic [8:0] e_m;
    int edg = 0;
    int err_total = 0;
    int checks_done = 0;
    always #50 pclk = ~pclk;
    always @(posedge pclk or negedge presetn)
        if (!presetn) edg <= 0;
        else edg <= edg + 1;
    dtc_timers dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .pins(pins),
        .vector_ack_a(ack_a), .vector_ack_b(ack_b), .timer_a_overflow_flag(fa),
        .timer_b_overflow_flag(fb));
    dtc_pin_model u_pins (.pclk(pclk), .go(go), .gate(gate), .pins(pins));
    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] h0, l0,
            input int n);
        logic [7:0] h, l;
        logic o;
        h = h0;
        l = l0;
        o = 1'b0;
        for (int i = 0; i < n; i++)
            case (m)
                2'd0: begin
                    {h, l[4:0]} = {h, l[4:0]} + 13'h1;
                    o |= {h, l[4:0]} == 13'h0;
                end
                2'd1: begin
                    {h, l} = {h, l} + 16'h1;
                    o |= {h, l} == 16'h0;
                end
                default: begin
                    l = l + 8'h1;
                    o |= l == 8'h0;
                    if (m == 2'd2 && l == 8'h0) l = h;
                end
            endcase
        return {o, h, l};
    endfunction
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
            input logic [8:0] e);
        @(posedge pclk);
        rnd = lfsr(rnd);
        req <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, {rnd[31:8], d}, 4'hf};
        if (!w) q.push_back(e);
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (!rsp.pready);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic ack(input logic [1:0] v);
        ack_a <= v[0];
        ack_b <= v[1];
        @(posedge pclk);
        ack_a <= 1'b0;
        ack_b <= 1'b0;
    endtask
    task automatic stop_test();
        $display("mismatches %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge pclk)
        if (req.psel && req.penable && rsp.pready && !req.pwrite) begin
            e_m = q.pop_front();
            chk({rsp.pslverr, rsp.prdata}, {e_m[8], 24'h0, e_m[7:0]});
        end
    initial begin
        repeat (16'h4e20) @(posedge pclk);
        err_total++;
        stop_test();
    end
    // ----------------
    // scenarios
    // ----------------
    initial begin
        logic [7:0] h, l, hb, lb;
        logic [16:0] r;
        logic [8:0] hs;
        int n;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 8'h87; i < 8'h90; i++)
            apb(0, i[7:0], 0, (i < 8'h88 || i > 8'h8e) ? 9'h100 : 9'h000);
        apb(1, 8'h8e, 8'hff, 0);
        apb(0, 8'h8e, 0, 9'h000);
        apb(1, 8'h88, 8'haf, 0);
        apb(0, 8'h88, 0, 9'h0af);
        ack(2'b01);
        apb(0, 8'h88, 0, 9'h08f);
        ack(2'b10);
        apb(0, 8'h88, 0, 9'h00f);
        apb(1, 8'h88, 8'h00, 0);
        foreach (CFG[k]) begin
            rnd = lfsr(rnd);
            h = CFG[k][4:3] == 2'd2 ? rnd[7:0] : 8'hff;
            l = rnd[15:8] | 8'hf0;
            hb = rnd[23:16];
            lb = rnd[31:24];
            n = CFG[k][1] && !CFG[k][0] ? 0 : CFG[k][2] ? 3 : 15;
            apb(1, 8'h89, {4'h3, CFG[k][1], CFG[k][2], CFG[k][4:3]}, 0);
            apb(1, 8'h8a, l, 0);
            apb(1, 8'h8c, h, 0);
            apb(1, 8'h8b, lb, 0);
            apb(1, 8'h8d, hb, 0);
            gate <= {rnd[0], CFG[k][0]};
            go <= 1'b1;
            while (edg % 12 != 3) @(posedge pclk);
            apb(1, 8'h88, 8'h50, 0);
            go <= 1'b0;
            repeat (178) @(posedge pclk);
            r = step(CFG[k][4:3], h, l, n);
            hs = {1'b0, h} + 9'(n);
            apb(0, 8'h88, 0, {1'b0, CFG[k][4:3] == 2'd3 && hs[8], 1'b1, r[16], 5'h10});
            ack(2'b11);
            apb(0, 8'h88, 0, 9'h050);
            apb(1, 8'h88, 8'h00, 0);
            if (n == 15) r = step(CFG[k][4:3], h, l, 16);
            hs = {1'b0, h} + 9'h10;
            apb(0, 8'h8a, 0, {1'b0, r[7:0]});
            apb(0, 8'h8c, 0, {1'b0, CFG[k][4:3] == 2'd3 ? hs[7:0] : r[15:8]});
            apb(0, 8'h8b, 0, {1'b0, lb});
            apb(0, 8'h8d, 0, {1'b0, hb});
        end
        stop_test();
    end
endmodule // tb_dual_timer_counter_modes
`default_nettype wire
